// file: rtl/modem_regs.sv
// Purpose: Modem register bank
// Assumes: Host on SPI pins; modem inputs on clk_sys
// Notes:   Reads have no side effects; unmapped and read-only writes are ignored
//
// Functional notes
// - Gain field codes 001 to 110 select six steps
// - Low-band current holds 00; others reserved; the register stores and outputs any code as written
// - High-band current code 11 gives 150 percent
// - Access pointer RW, resets zero, marks buffer access
// - Transmit base RW, resets 0x80
// - Receive base RW, resets 0x00
// - Read-only start of last received packet
// - Mask bit set blocks that interrupt; resets zero
// - Writing one clears the matching flag
// - Flag bits: timeout down to detection hit
// - Read-only payload byte count of last packet
// - Sixteen-bit good header count, two read bytes
// - Sixteen-bit good packet count, two read bytes
// - Sleep mode clears both counters
// - Status: coding rate plus five modem bits
`timescale 1ns/1ns
`include "modem_regs_map.svh"
module modem_regs
    import modem_regs_pkg::*;
(
    input  wire logic        clk_sys,               // System clock, 100 MHz
    input  wire logic        rst_b,                 // Asynchronous reset, active low
    input  wire logic        spi_sck,               // SPI clock pin
    input  wire logic        spi_nss_b,             // SPI select pin, active low
    input  wire logic        spi_mosi,              // SPI data in pin
    input  wire logic [7:0]  event_pulse,           // Modem events, one-cycle pulses
    input  wire logic        packet_ok_pulse,       // Good packet received
    input  wire logic        sleep_mode,            // Device is in sleep mode
    input  wire logic        rx_mode_entry,         // One-cycle pulse on entry into receive
    input  wire logic        rx_packet_store,       // Latch start and length of a packet
    input  wire byte_t       rx_packet_start,       // Buffer location of packet start
    input  wire byte_t       rx_packet_length,      // Payload byte count of packet
    input  wire logic [2:0]  header_code_rate,      // Coding rate from last header
    input  wire logic [4:0]  demod_bits_in,         // Clear, hdr valid, rx, sync, detect
    input  wire logic        buf_ptr_advance,       // Buffer logic stepped the pointer
    output logic             spi_miso,              // SPI data out
    output logic             spi_miso_oe,           // High while miso is driven
    output logic             irq,                   // Interrupt, active high
    output logic [5:0]       gain_step_sel,         // One-hot gain step, bit 0 maximum
    output logic [1:0]       low_band_amp_current,  // Low-band current field
    output logic [1:0]       high_band_amp_current, // High-band current field
    output logic             high_band_boost,       // High-band current at 150 percent
    output byte_t            buffer_access_pointer, // Buffer location for SPI data
    output byte_t            tx_buffer_base,        // Modulator payload start
    output byte_t            rx_buffer_base         // Demodulator payload start
);

    // Reset synchroniser
    logic        rst_meta_q;  // First stage, read only by the second
    logic        rst_n;       // Released copy used by the design

    // Registers
    byte_t       amp_ctrl_q;        // Amplifier control register
    byte_t       access_ptr_q;      // Buffer access pointer
    byte_t       tx_base_q;         // Transmit base
    byte_t       rx_base_q;         // Receive base
    byte_t       last_start_q;      // Start of last packet
    byte_t       event_mask_q;      // Event mask
    byte_t       event_flags_q;     // Event flags
    byte_t       event_flags_d;
    byte_t       payload_len_q;     // Payload bytes of last packet
    count_t      hdr_count_q;       // Good header count
    count_t      pkt_count_q;       // Good packet count
    logic [2:0]  code_rate_q;       // Coding rate of last header
    logic [4:0]  demod_bits_q;      // Modem status bits
    logic [5:0]  gain_sel_q;        // Decoded gain step
    logic        hb_boost_q;        // Decoded high-band boost
    logic        irq_q;             // Interrupt output flop

    // SPI side
    reg_addr_t   rd_addr;           // Address being read
    byte_t       rd_data;           // Read mux result
    logic        wr_stb;            // Write strobe
    reg_addr_t   wr_addr;           // Write address
    byte_t       wr_data;           // Write data
    logic        miso_q;            // From the port flop
    logic        miso_oe_q;         // From the port flop

    // Release reset through two flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // SPI register port
    spi_reg_port u_spi (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .sck_pin   (spi_sck),
        .nss_b_pin (spi_nss_b),
        .mosi_pin  (spi_mosi),
        .rd_data   (rd_data),
        .rd_addr   (rd_addr),
        .wr_stb    (wr_stb),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .miso      (miso_q),
        .miso_oe   (miso_oe_q)
    );

    // Write decode
    wire wr_amp   = wr_stb & (wr_addr == `OFS_RX_AMP_CONTROL);
    wire wr_ptr   = wr_stb & (wr_addr == `OFS_BUFFER_ACCESS_PTR);
    wire wr_txb   = wr_stb & (wr_addr == `OFS_TX_BUFFER_BASE);
    wire wr_rxb   = wr_stb & (wr_addr == `OFS_RX_BUFFER_BASE);
    wire wr_mask  = wr_stb & (wr_addr == `OFS_EVENT_MASK);
    wire wr_flags = wr_stb & (wr_addr == `OFS_EVENT_FLAGS);

    // Clear mask: only ones written to the flag register clear
    wire byte_t flag_clear = wr_flags ? wr_data : 8'h00;

    // Gain field and its validity
    wire [2:0]  gain_code  = amp_ctrl_q[`GAIN_STEP_HI:`GAIN_STEP_LO];
    wire        gain_valid = (gain_code >= `GAIN_CODE_MAX) &&
                             (gain_code <= `GAIN_CODE_MIN);
    wire [2:0]  gain_index = gain_code - `GAIN_CODE_MAX;
    wire [5:0]  gain_onehot = 6'h01 << gain_index;
    wire [1:0]  hb_code    = amp_ctrl_q[`HIGH_BAND_CUR_HI:`HIGH_BAND_CUR_LO];

    // Counter control: sleep or receive entry clears, events count
    wire        count_clear = sleep_mode | rx_mode_entry;
    wire        hdr_inc     = event_pulse[EV_HEADER_OK];

    // Read mux
    always_comb begin
        unique case (rd_addr)
            `OFS_RX_AMP_CONTROL:    rd_data = amp_ctrl_q;
            `OFS_BUFFER_ACCESS_PTR: rd_data = access_ptr_q;
            `OFS_TX_BUFFER_BASE:    rd_data = tx_base_q;
            `OFS_RX_BUFFER_BASE:    rd_data = rx_base_q;
            `OFS_LAST_PACKET_START: rd_data = last_start_q;
            `OFS_EVENT_MASK:        rd_data = event_mask_q;
            `OFS_EVENT_FLAGS:       rd_data = event_flags_q;
            `OFS_RX_PAYLOAD_LENGTH: rd_data = payload_len_q;
            `OFS_GOOD_HDR_CNT_HIGH: rd_data = hdr_count_q[15:8];
            `OFS_GOOD_HDR_CNT_LOW:  rd_data = hdr_count_q[7:0];
            `OFS_GOOD_PKT_CNT_HIGH: rd_data = pkt_count_q[15:8];
            `OFS_GOOD_PKT_CNT_LOW:  rd_data = pkt_count_q[7:0];
            `OFS_DEMOD_STATE:       rd_data = {code_rate_q, demod_bits_q};
            default:                rd_data = 8'h00; // Unmapped reads zero
        endcase
    end

    // Amplifier control register; the low-band field is stored as written
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            amp_ctrl_q <= `RST_RX_AMP_CONTROL;
        end else if (wr_amp) begin
            amp_ctrl_q <= wr_data;
        end
    end

    // Decoded amplifier settings; unused gain codes keep the last step
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gain_sel_q <= `RST_GAIN_ONEHOT;
            hb_boost_q <= 1'b0;
        end else begin
            if (gain_valid) begin
                gain_sel_q <= gain_onehot;
            end
            hb_boost_q <= (hb_code == `AMP_CUR_BOOST);
        end
    end

    // Buffer pointers; a host write wins over an advance
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            access_ptr_q <= `RST_BUFFER_ACCESS_PTR;
            tx_base_q    <= `RST_TX_BUFFER_BASE;
            rx_base_q    <= `RST_RX_BUFFER_BASE;
        end else begin
            if (wr_ptr) begin
                access_ptr_q <= wr_data;
            end else if (buf_ptr_advance) begin
                access_ptr_q <= access_ptr_q + 8'h01;
            end
            if (wr_txb) begin
                tx_base_q <= wr_data;
            end
            if (wr_rxb) begin
                rx_base_q <= wr_data;
            end
        end
    end

    // Last packet start and length, captured from the demodulator
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            last_start_q  <= 8'h00;
            payload_len_q <= 8'h00;
        end else if (rx_packet_store) begin
            last_start_q  <= rx_packet_start;
            payload_len_q <= rx_packet_length;
        end
    end

    // Event flags: a new event wins over a clear in the same cycle
    always_comb begin
        event_flags_d = (event_flags_q & ~flag_clear) | event_pulse;
    end

    // Mask and flag registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            event_mask_q  <= `RST_EVENT_MASK;
            event_flags_q <= `RST_EVENT_FLAGS;
        end else begin
            if (wr_mask) begin
                event_mask_q <= wr_data;
            end
            event_flags_q <= event_flags_d;
        end
    end

    // Interrupt: any flag whose mask bit is clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(event_flags_d & ~(wr_mask ? wr_data : event_mask_q));
        end
    end

    // Good header and packet counters; clearing wins over counting
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hdr_count_q <= 16'h0000;
            pkt_count_q <= 16'h0000;
        end else if (count_clear) begin
            hdr_count_q <= 16'h0000;
            pkt_count_q <= 16'h0000;
        end else begin
            if (hdr_inc) begin
                hdr_count_q <= hdr_count_q + 16'h0001;
            end
            if (packet_ok_pulse) begin
                pkt_count_q <= pkt_count_q + 16'h0001;
            end
        end
    end

    // Modem status copy
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            code_rate_q  <= 3'h0;
            demod_bits_q <= `RST_DEMOD_BITS;
        end else begin
            code_rate_q  <= header_code_rate;
            demod_bits_q <= demod_bits_in;
        end
    end

    // Outputs, each straight from a flop
    assign spi_miso              = miso_q;
    assign spi_miso_oe           = miso_oe_q;
    assign irq                   = irq_q;
    assign gain_step_sel         = gain_sel_q;
    assign low_band_amp_current  = amp_ctrl_q[`LOW_BAND_CUR_HI:`LOW_BAND_CUR_LO];
    assign high_band_amp_current = hb_code;
    assign high_band_boost       = hb_boost_q;
    assign buffer_access_pointer = access_ptr_q;
    assign tx_buffer_base        = tx_base_q;
    assign rx_buffer_base        = rx_base_q;

endmodule

// file: rtl/modem_regs_map.svh
// Purpose: Offsets, fields and reset values of the register bank
// Assumes: Seven-bit addresses from the SPI command byte
// Notes:   Definitions only
`ifndef MODEM_REGS_MAP_SVH
`define MODEM_REGS_MAP_SVH

// Register offsets
`define OFS_RX_AMP_CONTROL      7'h0c
`define OFS_BUFFER_ACCESS_PTR   7'h0d
`define OFS_TX_BUFFER_BASE      7'h0e
`define OFS_RX_BUFFER_BASE      7'h0f
`define OFS_LAST_PACKET_START   7'h10
`define OFS_EVENT_MASK          7'h11
`define OFS_EVENT_FLAGS         7'h12
`define OFS_RX_PAYLOAD_LENGTH   7'h13
`define OFS_GOOD_HDR_CNT_HIGH   7'h14
`define OFS_GOOD_HDR_CNT_LOW    7'h15
`define OFS_GOOD_PKT_CNT_HIGH   7'h16
`define OFS_GOOD_PKT_CNT_LOW    7'h17
`define OFS_DEMOD_STATE         7'h18

// Field positions inside the amplifier control register
`define GAIN_STEP_HI            7
`define GAIN_STEP_LO            5
`define LOW_BAND_CUR_HI         4
`define LOW_BAND_CUR_LO         3
`define AMP_RESERVED_BIT        2
`define HIGH_BAND_CUR_HI        1
`define HIGH_BAND_CUR_LO        0

// Field codes
`define GAIN_CODE_MAX           3'h1
`define GAIN_CODE_MIN           3'h6
`define AMP_CUR_DEFAULT         2'h0
`define AMP_CUR_BOOST           2'h3

// Reset values
`define RST_RX_AMP_CONTROL      8'h20
`define RST_BUFFER_ACCESS_PTR   8'h00
`define RST_TX_BUFFER_BASE      8'h80
`define RST_RX_BUFFER_BASE      8'h00
`define RST_EVENT_MASK          8'h00
`define RST_EVENT_FLAGS         8'h00
`define RST_DEMOD_BITS          5'h10
`define RST_GAIN_ONEHOT         6'h01

`endif

// file: rtl/modem_regs_pkg.sv
// Purpose: Shared types of the modem register bank
// Assumes: Used together with modem_regs_map.svh
// Notes:   Types only
package modem_regs_pkg;

    typedef logic [7:0]  byte_t;      // One register
    typedef logic [6:0]  reg_addr_t;  // Register address
    typedef logic [15:0] count_t;     // Good header or packet count

    // Bit positions of the event flags and their mask bits
    typedef enum logic [2:0] {
        EV_DETECT_HIT      = 3'b000,
        EV_HOP_CHANGE      = 3'b001,
        EV_DETECT_COMPLETE = 3'b010,
        EV_TX_COMPLETE     = 3'b011,
        EV_HEADER_OK       = 3'b100,
        EV_PAYLOAD_FAIL    = 3'b101,
        EV_RX_COMPLETE     = 3'b110,
        EV_RX_TIMEOUT      = 3'b111
    } event_bit_e;

    // Phase of an SPI frame
    typedef enum logic {
        PH_ADDR = 1'b0,
        PH_DATA = 1'b1
    } spi_phase_e;

endpackage

// file: rtl/spi_reg_port.sv
// Purpose: SPI slave for register access
// Assumes: Mode 0, MSB first; first byte is write flag plus address; SCK at most clk_sys/20
// Notes:   Bursts auto-increment the address; all input pins pass two flip-flops
`timescale 1ns/1ns
module spi_reg_port
    import modem_regs_pkg::*;
(
    input  wire logic      clk_sys,    // System clock
    input  wire logic      rst_n,      // Synchronised reset, active low
    input  wire logic      sck_pin,    // SPI clock pin
    input  wire logic      nss_b_pin,  // SPI select pin, active low
    input  wire logic      mosi_pin,   // SPI data in pin
    input  wire byte_t     rd_data,    // Read data for rd_addr
    output reg_addr_t      rd_addr,    // Address of the byte about to be read
    output logic           wr_stb,     // One-cycle write strobe
    output reg_addr_t      wr_addr,    // Write address
    output byte_t          wr_data,    // Write data
    output logic           miso,       // SPI data out
    output logic           miso_oe     // High while the slave drives miso
);

    logic [2:0]  sync1_q;      // First stage, read only by the second
    logic [2:0]  sync2_q;      // Second stage: {sck, nss_b, mosi}
    logic        sck_prev_q;   // Previous synchronised clock
    logic [2:0]  bit_cnt_q;    // Bits received in current byte
    logic [6:0]  shift_in_q;   // Incoming bits
    byte_t       shift_out_q;  // Outgoing bits
    spi_phase_e  phase_q;      // Address or data phase
    logic        write_q;      // Frame is a write
    reg_addr_t   addr_q;       // Current burst address
    logic        load_q;       // Load read data next cycle
    logic        wr_stb_q;
    reg_addr_t   wr_addr_q;
    byte_t       wr_data_q;
    logic        miso_q;
    logic        miso_oe_q;

    // Decoded pin events
    wire         sck_s     = sync2_q[2];
    wire         nss_b_s   = sync2_q[1];
    wire         mosi_s    = sync2_q[0];
    wire         sck_rise  = sck_s & ~sck_prev_q;
    wire         sck_fall  = ~sck_s & sck_prev_q;
    wire         byte_done = sck_rise & (bit_cnt_q == 3'h7) & ~nss_b_s;
    wire byte_t  byte_in   = {shift_in_q, mosi_s};

    // Two-stage pin synchroniser
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q    <= 3'h2;
            sync2_q    <= 3'h2;
            sck_prev_q <= 1'b0;
        end else begin
            sync1_q    <= {sck_pin, nss_b_pin, mosi_pin};
            sync2_q    <= sync1_q;
            sck_prev_q <= sync2_q[2];
        end
    end

    // Receive side: bit count, address phase and burst address
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_q  <= 3'h0;
            shift_in_q <= 7'h00;
            phase_q    <= PH_ADDR;
            write_q    <= 1'b0;
            addr_q     <= 7'h00;
            load_q     <= 1'b0;
        end else if (nss_b_s) begin
            // Deselected: frame ends
            bit_cnt_q <= 3'h0;
            phase_q   <= PH_ADDR;
            load_q    <= 1'b0;
        end else begin
            load_q <= 1'b0;
            if (sck_rise) begin
                bit_cnt_q  <= bit_cnt_q + 3'h1;
                shift_in_q <= byte_in[6:0];
            end
            if (byte_done) begin
                unique case (phase_q)
                    PH_ADDR: begin
                        phase_q <= PH_DATA;
                        write_q <= byte_in[7];
                        addr_q  <= byte_in[6:0];
                        load_q  <= ~byte_in[7];
                    end
                    PH_DATA: begin
                        addr_q <= addr_q + 7'h01;
                        load_q <= ~write_q;
                    end
                endcase
            end
        end
    end

    // Write strobe after each complete data byte of a write frame
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_stb_q  <= 1'b0;
            wr_addr_q <= 7'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_stb_q <= byte_done & (phase_q == PH_DATA) & write_q;
            if (byte_done) begin
                wr_addr_q <= addr_q;
                wr_data_q <= byte_in;
            end
        end
    end

    // Transmit side: load read data, present one bit per falling edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_out_q <= 8'h00;
            miso_q      <= 1'b0;
            miso_oe_q   <= 1'b0;
        end else begin
            miso_oe_q <= ~nss_b_s;
            if (nss_b_s) begin
                shift_out_q <= 8'h00;
                miso_q      <= 1'b0;
            end else if (load_q) begin
                shift_out_q <= rd_data;
            end else if (sck_fall) begin
                miso_q      <= shift_out_q[7];
                shift_out_q <= {shift_out_q[6:0], 1'b0};
            end
        end
    end

    assign rd_addr = addr_q;
    assign wr_stb  = wr_stb_q;
    assign wr_addr = wr_addr_q;
    assign wr_data = wr_data_q;
    assign miso    = miso_q;
    assign miso_oe = miso_oe_q;

endmodule

// file: sim/spi_host.sv
// Purpose: SPI host model for register frames
// Assumes: Mode 0, MSB first, SCK high for 12 and low for 13 clk_sys per bit
// Notes:   SCK low, select high when idle
`timescale 1ns/1ns
module spi_host
    import modem_regs_pkg::*;
(
    input  wire logic clk_sys,  // System clock
    output logic      sck,      // SPI clock
    output logic      nss_b,    // Select, active low
    output logic      mosi,     // Data to the device
    input  wire logic miso,     // Data from the device
    input  wire logic miso_oe   // Device drives miso
);
    // Idle levels from time zero
    initial begin
        sck = 1'b0;
        nss_b = 1'b1;
        mosi = 1'b0;
    end

    // Command and data byte; got is the byte read back
    task automatic xfer(input byte_t cmd, input byte_t dat, output byte_t got);
        logic [15:0] sh;
        sh = {cmd, dat};
        got = 8'h00;
        @(posedge clk_sys) nss_b <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk_sys) mosi <= sh[i];
            repeat (12) @(posedge clk_sys);
            sck <= 1'b1;
            got = {got[6:0], miso};
            repeat (12) @(posedge clk_sys);
            sck <= 1'b0;
        end
        // Select held so the write lands in the frame
        repeat (4) @(posedge clk_sys);
        nss_b <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule

// file: sim/modem_regs_chk.sv
// Purpose: Port assertions of the register bank
// Assumes: Writes only while select is low
// Notes:   Bound to every modem_regs instance
`timescale 1ns/1ns
module modem_regs_chk
    import modem_regs_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       spi_nss_b,
    input wire logic [7:0] event_pulse,
    input wire logic       buf_ptr_advance,
    input wire logic       irq,
    input wire logic [5:0] gain_step_sel,
    input wire logic [1:0] low_band_amp_current,
    input wire logic [1:0] high_band_amp_current,
    input wire logic       high_band_boost,
    input wire byte_t      buffer_access_pointer,
    input wire byte_t      tx_buffer_base,
    input wire byte_t      rx_buffer_base
);
    logic ev_seen_q;  // Some event arrived since reset

    // Any event since reset
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ev_seen_q <= 1'b0;
        end else if (|event_pulse) begin
            ev_seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_GAIN_ONEHOT: assert property ($onehot(gain_step_sel))
        else $error("gain not one-hot");
    AST_AMP_HOLD: assert property (spi_nss_b [*8] |-> $stable(gain_step_sel)
        && $stable(low_band_amp_current)) else $error("amp moved");
    AST_BOOST: assert property ($past(high_band_amp_current) == high_band_amp_current
        |-> high_band_boost == (high_band_amp_current == 2'h3)) else $error("boost wrong");
    AST_PTR_ADV: assert property (buf_ptr_advance && spi_nss_b
        |=> buffer_access_pointer == $past(buffer_access_pointer) + 8'h01)
        else $error("no step");
    AST_BASE_HOLD: assert property (spi_nss_b [*8] |-> $stable(tx_buffer_base)
        && $stable(rx_buffer_base)) else $error("base moved");
    AST_IRQ_QUIET: assert property (!ev_seen_q |-> !irq)
        else $error("irq early");
    AST_IRQ_FALL: assert property ($fell(irq) |-> !spi_nss_b)
        else $error("irq fell");
    AST_IRQ_RISE: assert property ($rose(irq) |-> $past(event_pulse) != 8'h00 || !spi_nss_b)
        else $error("irq rose");

    cover property ($rose(irq));
    cover property ($fell(irq));
    cover property (buf_ptr_advance);
endmodule

bind modem_regs modem_regs_chk modem_regs_chk_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .spi_nss_b(spi_nss_b), .event_pulse(event_pulse),
    .buf_ptr_advance(buf_ptr_advance), .irq(irq), .gain_step_sel(gain_step_sel),
    .low_band_amp_current(low_band_amp_current), .high_band_amp_current(high_band_amp_current),
    .high_band_boost(high_band_boost), .buffer_access_pointer(buffer_access_pointer),
    .tx_buffer_base(tx_buffer_base), .rx_buffer_base(rx_buffer_base)
);

// file: sim/modem_regs_test.sv
// Purpose: Bench of the register bank
// Assumes: Two-byte host frames
// Notes:   Fixed seed, corner cases
`timescale 1ns/1ns
module modem_regs_test
    import modem_regs_pkg::*;
;
    logic  clk_sys, rst_b, sck, nss_b, mosi, miso, oe, irq, boost;
    logic  pkt_ok, sleep, rx_entry, store, adv;
    logic  [7:0] ev;
    logic  [2:0] cr;
    logic  [4:0] dbits;
    logic  [5:0] gsel, g;
    logic  [1:0] lbc, hbc;
    byte_t pstart, plen, ptr, txb, rxb, m;
    byte_t v [32];
    int    n_mismatch, checks, nh, np;

    // Free-running 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    spi_host host_i (.clk_sys(clk_sys), .sck(sck), .nss_b(nss_b), .mosi(mosi), .miso(miso),
        .miso_oe(oe));
    modem_regs modem_regs_i (.clk_sys(clk_sys), .rst_b(rst_b), .spi_sck(sck),
        .spi_nss_b(nss_b), .spi_mosi(mosi), .event_pulse(ev), .packet_ok_pulse(pkt_ok),
        .sleep_mode(sleep), .rx_mode_entry(rx_entry), .rx_packet_store(store),
        .rx_packet_start(pstart), .rx_packet_length(plen), .header_code_rate(cr),
        .demod_bits_in(dbits), .buf_ptr_advance(adv), .spi_miso(miso), .spi_miso_oe(oe),
        .irq(irq), .gain_step_sel(gsel), .low_band_amp_current(lbc),
        .high_band_amp_current(hbc), .high_band_boost(boost), .buffer_access_pointer(ptr),
        .tx_buffer_base(txb), .rx_buffer_base(rxb));

    // Reset value of each register address
    function automatic byte_t rst_val(input int a);
        return (a == 14) ? 8'h80 : (a == 12) ? 8'h20 : (a == 24) ? 8'h10 : 8'h00;
    endfunction

    // Compare and count
    task automatic chk(input string nm, input byte_t e, input byte_t g_in);
        checks++;
        if (g_in !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g_in);
        end
    endtask

    task automatic wr(input byte_t a, input byte_t d);
        byte_t t;
        host_i.xfer(a | 8'h80, d, t);
    endtask

    task automatic rd(input byte_t a, input byte_t e);
        byte_t t;
        host_i.xfer(a, 8'h00, t);
        chk($sformatf("register %h", a), e, t);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        end_sim();
    end

    // Main sequence
    initial begin
        {rst_b, ev, pkt_ok, sleep, rx_entry, store, adv, pstart, plen, cr} = '0;
        dbits = 5'h10;
        n_mismatch = 0;
        checks = 0;
        void'($urandom(56484));
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk_sys);
        for (int a = 12; a <= 24; a++) rd(a, rst_val(a));
        chk("miso enable", 8'h00, oe);
        // Random writes; read-only place refuses
        for (int a = 13; a <= 17; a++) begin
            v[a] = $urandom;
            wr(a, v[a]);
            rd(a, (a == 16) ? 8'h00 : v[a]);
        end
        chk("pointer", v[13], ptr);
        chk("tx base", v[14], txb);
        chk("rx base", v[15], rxb);
        wr(8'h7f, 8'hff);
        rd(8'h7f, 8'h00);
        @(posedge clk_sys) adv <= 1'b1;
        @(posedge clk_sys) adv <= 1'b0;
        #1 chk("pointer step", v[13] + 8'h01, ptr);
        // Every gain code; low-band stays default
        g = 6'h01;
        for (int k = 0; k < 8; k++) begin
            wr(12, {k[2:0], 3'b000, k[1:0]});
            if (k >= 1 && k <= 6) g = 6'h01 << (k - 1);
            rd(12, {k[2:0], 3'b000, k[1:0]});
            chk("gain step", g, gsel);
            chk("boost", k[1:0] == 2'h3, boost);
            chk("amp current", {2'b00, k[1:0]}, {lbc, hbc});
        end
        // Each event against a random mask
        m = $urandom;
        m[0] = 1'b0;
        m[7] = 1'b1;
        wr(17, m);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys) ev <= 8'h01 << i;
            @(posedge clk_sys) ev <= 8'h00;
            repeat (2) @(posedge clk_sys);
            #1 chk("irq", !m[i], irq);
            rd(18, 8'h01 << i);
            wr(18, ~(8'h01 << i));
            rd(18, 8'h01 << i);
            wr(18, 8'h01 << i);
            rd(18, 8'h00);
            chk("irq clear", 8'h00, irq);
        end
        // Header count past one byte, packet count seven less
        @(posedge clk_sys) rx_entry <= 1'b1;
        @(posedge clk_sys) rx_entry <= 1'b0;
        nh = 256 + $urandom % 40;
        np = nh - 7;
        for (int j = 0; j < nh; j++) begin
            @(posedge clk_sys) ev <= 8'h10;
            pkt_ok <= (j < np);
        end
        @(posedge clk_sys) ev <= 8'h00;
        pkt_ok <= 1'b0;
        rd(20, nh[15:8]);
        rd(21, nh[7:0]);
        rd(22, np[15:8]);
        rd(23, np[7:0]);
        wr(18, 8'hff);
        @(posedge clk_sys) sleep <= 1'b1;
        repeat (3) @(posedge clk_sys);
        sleep <= 1'b0;
        for (int a = 20; a < 24; a++) rd(a, 8'h00);
        // Random packet start, length, status
        for (int i = 0; i < 3; i++) v[i] = $urandom;
        @(posedge clk_sys) store <= 1'b1;
        pstart <= v[0];
        plen <= v[1];
        {cr, dbits} <= v[2];
        @(posedge clk_sys) store <= 1'b0;
        rd(16, v[0]);
        rd(19, v[1]);
        rd(24, v[2]);
        end_sim();
    end
endmodule
